// File: rtl/olendec_pkg.sv
package olendec_pkg;

	// ----------------------------------------
	// operation classes
	// ----------------------------------------
	typedef enum logic [4:0] {
		OLD_OP_OTHER           = 5'h00,
		OLD_OP_JUMP_BIT_SET    = 5'h01,
		OLD_OP_JUMP_BIT_CLEAR  = 5'h02,
		OLD_OP_PAGE_CALL       = 5'h03,
		OLD_OP_INT_RETURN      = 5'h04,
		OLD_OP_JUMP_ACC_ZERO   = 5'h05,
		OLD_OP_JUMP_ACC_NZERO  = 5'h06,
		OLD_OP_OR_BIT_CARRY    = 5'h07,
		OLD_OP_LOAD_REG_IMM    = 5'h08,
		OLD_OP_SHORT_JUMP      = 5'h09,
		OLD_OP_AND_BIT_CARRY   = 5'h0a,
		OLD_OP_DIVIDE          = 5'h0b,
		OLD_OP_MOVE_DIR_DIR    = 5'h0c,
		OLD_OP_STORE_REG_DIR   = 5'h0d,
		OLD_OP_LOAD_PTR_IMM    = 5'h0e,
		OLD_OP_STORE_CARRY_BIT = 5'h0f,
		OLD_OP_CODE_READ       = 5'h10,
		OLD_OP_SUB_BORROW      = 5'h11,
		OLD_OP_INC_PTR         = 5'h12,
		OLD_OP_MULTIPLY        = 5'h13,
		OLD_OP_LOAD_REG_DIR    = 5'h14,
		OLD_OP_COMPARE_JUMP    = 5'h15,
		OLD_OP_CLEAR_BIT       = 5'h16,
		OLD_OP_CLEAR_CARRY     = 5'h17,
		OLD_OP_PAGE_JUMP       = 5'h18,
		OLD_OP_UNDEFINED       = 5'h1f
	} olendec_op_t;

	// ----------------------------------------
	// operand forms
	// ----------------------------------------
	typedef enum logic [3:0] {
		OLD_FORM_NONE         = 4'h0,
		OLD_FORM_BIT_REL      = 4'h1,
		OLD_FORM_PAGE_ADDR    = 4'h2,
		OLD_FORM_REL          = 4'h3,
		OLD_FORM_BIT          = 4'h4,
		OLD_FORM_REG_IMM      = 4'h5,
		OLD_FORM_ACC_AUX      = 4'h6,
		OLD_FORM_DIR_DIR      = 4'h7,
		OLD_FORM_DIR_REG      = 4'h8,
		OLD_FORM_PTR_IMM16    = 4'h9,
		OLD_FORM_ACC_PTR      = 4'ha,
		OLD_FORM_ACC_REG      = 4'hb,
		OLD_FORM_PTR          = 4'hc,
		OLD_FORM_REG_DIR      = 4'hd,
		OLD_FORM_ACC_IMM_REL  = 4'he,
		OLD_FORM_ACC_DIR_REL  = 4'hf
	} olendec_form_t;

	// register-with-immediate compare reuses reg_imm with a relative flag
	localparam logic [1:0] OLD_LEN_1 = 2'h1;
	localparam logic [1:0] OLD_LEN_2 = 2'h2;
	localparam logic [1:0] OLD_LEN_3 = 2'h3;

	localparam int OLD_ADDR_W = 16;
	localparam int OLD_PAGE_W = 11;
	localparam int OLD_REG_W  = 3;

	localparam logic [7:0] OLD_OPC_JB      = 8'h20;
	localparam logic [7:0] OLD_OPC_JNB     = 8'h30;
	localparam logic [7:0] OLD_OPC_PCALL   = 8'h31;
	localparam logic [7:0] OLD_OPC_IRET    = 8'h32;
	localparam logic [7:0] OLD_OPC_JZ      = 8'h60;
	localparam logic [7:0] OLD_OPC_JNZ     = 8'h70;
	localparam logic [7:0] OLD_OPC_ORC     = 8'h72;
	localparam logic [4:0] OLD_GRP_LDIMM   = 5'h0f;
	localparam logic [7:0] OLD_OPC_SJ      = 8'h80;
	localparam logic [7:0] OLD_OPC_ANDC    = 8'h82;
	localparam logic [7:0] OLD_OPC_DIV     = 8'h84;
	localparam logic [7:0] OLD_OPC_MOVDD   = 8'h85;
	localparam logic [4:0] OLD_GRP_STDIR   = 5'h11;
	localparam logic [7:0] OLD_OPC_LDPTR   = 8'h90;
	localparam logic [7:0] OLD_OPC_STC     = 8'h92;
	localparam logic [7:0] OLD_OPC_CREAD   = 8'h93;
	localparam logic [4:0] OLD_GRP_SUBTRACT_WITH_BORROW    = 5'h13;
	localparam logic [7:0] OLD_OPC_INCPTR  = 8'ha3;
	localparam logic [7:0] OLD_OPC_MUL     = 8'ha4;
	localparam logic [7:0] OLD_OPC_RSVD    = 8'ha5;
	localparam logic [4:0] OLD_GRP_LDDIR   = 5'h15;
	localparam logic [7:0] OLD_OPC_CJAI    = 8'hb4;
	localparam logic [7:0] OLD_OPC_CJAD    = 8'hb5;
	localparam logic [4:0] OLD_GRP_CJRI    = 5'h17;
	localparam logic [7:0] OLD_OPC_CLRB    = 8'hc2;
	localparam logic [7:0] OLD_OPC_CLRC    = 8'hc3;
	localparam logic [4:0] OLD_PJ_LOW      = 5'h01;
	localparam logic [3:0] OLD_PCALL_LOW   = 4'h1;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		olendec_op_t   op;
		olendec_form_t form;
		logic [1:0]    length;
		logic [2:0]    reg_sel;
		logic          has_rel;
		logic          undefined;
	} olendec_dec_t;

	typedef struct packed {
		logic [15:0] pc;
		logic [7:0]  rel;
		logic [7:0]  low;
	} olendec_tgt_in_t;

endpackage

// File: rtl/olendec_target.sv
`timescale 1ns/1ps
// branch target arithmetic for relative and page forms
module olendec_target
	import olendec_pkg::*;
(
	input  wire logic [OLD_ADDR_W-1:0] next_pc,
	input  wire logic [7:0]            rel,
	input  wire logic [2:0]            page_hi,
	input  wire logic [7:0]            page_lo,
	output logic      [OLD_ADDR_W-1:0] rel_target,
	output logic      [OLD_ADDR_W-1:0] page_target
);
	// sign extension gives +127 / -128 around the next instruction
	assign rel_target  = next_pc + {{(OLD_ADDR_W-8){rel[7]}}, rel};
	// page bits come from the next instruction's address
	assign page_target = {next_pc[OLD_ADDR_W-1:OLD_PAGE_W], page_hi, page_lo};
endmodule // olendec_target

// File: rtl/olendec_top.sv
`timescale 1ns/1ps
// Overview of operation
// - 0x20 jump if bit set, three bytes
// - 0x30 jump if bit clear, three bytes
// - 0x31 page call, two bytes
// - 0x32 interrupt return, one byte
// - 0x70 jump if accumulator nonzero, two
// - 0x72 or bit into carry, two
// - 0x78-0x7f load register immediate, two
// - 0x84 divide accumulator by aux, one
// - 0x85 direct to direct move, three
// - 0x88-0x8f register to direct, two
// - 0x90 load data pointer immediate, three
// - 0x92 carry to direct bit, two
// - 0x93 code read at acc plus pointer
// - 0x98-0x9f subtract with borrow register, one
// - 0xa3 increment data pointer, one byte
// - 0xa4 multiply one byte; 0xa5 reserved
// - 0xa8-0xaf load register from direct, two
// - 0xb4, 0xb5, 0xb8-0xbf compare jump, three
// - one-byte offset, +127 to -128 range
// - page target within next instruction's page
module olendec_top
	import olendec_pkg::*;
(
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire logic                  opc_valid,
	input  wire logic [7:0]            opc,
	input  wire olendec_tgt_in_t       tgt_in,
	output logic      [1:0]            len_now,
	output olendec_dec_t               dec,
	output logic                       dec_valid,
	output logic      [OLD_ADDR_W-1:0] rel_target,
	output logic      [OLD_ADDR_W-1:0] page_target
);

	// ----------------------------------------
	// combinational decode
	// ----------------------------------------
	olendec_dec_t              next_dec;
	logic [OLD_ADDR_W-1:0]     next_pc;
	logic [OLD_ADDR_W-1:0]     rel_t;
	logic [OLD_ADDR_W-1:0]     page_t;

	always_comb begin
		next_dec           = '0;
		next_dec.op        = OLD_OP_OTHER;
		next_dec.form      = OLD_FORM_NONE;
		next_dec.length    = OLD_LEN_1;
		next_dec.reg_sel   = opc[2:0];
		if (opc == OLD_OPC_JB) begin
			next_dec.op      = OLD_OP_JUMP_BIT_SET;
			next_dec.form    = OLD_FORM_BIT_REL;
			next_dec.length  = OLD_LEN_3;
			next_dec.has_rel = 1'b1;
		end else if (opc == OLD_OPC_JNB) begin
			next_dec.op      = OLD_OP_JUMP_BIT_CLEAR;
			next_dec.form    = OLD_FORM_BIT_REL;
			next_dec.length  = OLD_LEN_3;
			next_dec.has_rel = 1'b1;
		end else if (opc[3:0] == OLD_PCALL_LOW && opc[4]) begin
			next_dec.op      = OLD_OP_PAGE_CALL;
			next_dec.form    = OLD_FORM_PAGE_ADDR;
			next_dec.length  = OLD_LEN_2;
		end else if (opc[4:0] == OLD_PJ_LOW) begin
			next_dec.op      = OLD_OP_PAGE_JUMP;
			next_dec.form    = OLD_FORM_PAGE_ADDR;
			next_dec.length  = OLD_LEN_2;
		end else if (opc == OLD_OPC_IRET) begin
			next_dec.op      = OLD_OP_INT_RETURN;
		end else if (opc == OLD_OPC_JZ) begin
			next_dec.op      = OLD_OP_JUMP_ACC_ZERO;
			next_dec.form    = OLD_FORM_REL;
			next_dec.length  = OLD_LEN_2;
			next_dec.has_rel = 1'b1;
		end else if (opc == OLD_OPC_JNZ) begin
			next_dec.op      = OLD_OP_JUMP_ACC_NZERO;
			next_dec.form    = OLD_FORM_REL;
			next_dec.length  = OLD_LEN_2;
			next_dec.has_rel = 1'b1;
		end else if (opc == OLD_OPC_ORC) begin
			next_dec.op      = OLD_OP_OR_BIT_CARRY;
			next_dec.form    = OLD_FORM_BIT;
			next_dec.length  = OLD_LEN_2;
		end else if (opc[7:3] == OLD_GRP_LDIMM) begin
			next_dec.op      = OLD_OP_LOAD_REG_IMM;
			next_dec.form    = OLD_FORM_REG_IMM;
			next_dec.length  = OLD_LEN_2;
		end else if (opc == OLD_OPC_SJ) begin
			next_dec.op      = OLD_OP_SHORT_JUMP;
			next_dec.form    = OLD_FORM_REL;
			next_dec.length  = OLD_LEN_2;
			next_dec.has_rel = 1'b1;
		end else if (opc == OLD_OPC_ANDC) begin
			next_dec.op      = OLD_OP_AND_BIT_CARRY;
			next_dec.form    = OLD_FORM_BIT;
			next_dec.length  = OLD_LEN_2;
		end else if (opc == OLD_OPC_DIV) begin
			next_dec.op      = OLD_OP_DIVIDE;
			next_dec.form    = OLD_FORM_ACC_AUX;
		end else if (opc == OLD_OPC_MOVDD) begin
			next_dec.op      = OLD_OP_MOVE_DIR_DIR;
			next_dec.form    = OLD_FORM_DIR_DIR;
			next_dec.length  = OLD_LEN_3;
		end else if (opc[7:3] == OLD_GRP_STDIR) begin
			next_dec.op      = OLD_OP_STORE_REG_DIR;
			next_dec.form    = OLD_FORM_DIR_REG;
			next_dec.length  = OLD_LEN_2;
		end else if (opc == OLD_OPC_LDPTR) begin
			next_dec.op      = OLD_OP_LOAD_PTR_IMM;
			next_dec.form    = OLD_FORM_PTR_IMM16;
			next_dec.length  = OLD_LEN_3;
		end else if (opc == OLD_OPC_STC) begin
			next_dec.op      = OLD_OP_STORE_CARRY_BIT;
			next_dec.form    = OLD_FORM_BIT;
			next_dec.length  = OLD_LEN_2;
		end else if (opc == OLD_OPC_CREAD) begin
			next_dec.op      = OLD_OP_CODE_READ;
			next_dec.form    = OLD_FORM_ACC_PTR;
		end else if (opc[7:3] == OLD_GRP_SUBTRACT_WITH_BORROW) begin
			next_dec.op      = OLD_OP_SUB_BORROW;
			next_dec.form    = OLD_FORM_ACC_REG;
		end else if (opc == OLD_OPC_INCPTR) begin
			next_dec.op      = OLD_OP_INC_PTR;
			next_dec.form    = OLD_FORM_PTR;
		end else if (opc == OLD_OPC_MUL) begin
			next_dec.op      = OLD_OP_MULTIPLY;
			next_dec.form    = OLD_FORM_ACC_AUX;
		end else if (opc == OLD_OPC_RSVD) begin
			// reserved byte is one long so fetch can step past it
			next_dec.op        = OLD_OP_UNDEFINED;
			next_dec.undefined = 1'b1;
		end else if (opc[7:3] == OLD_GRP_LDDIR) begin
			next_dec.op      = OLD_OP_LOAD_REG_DIR;
			next_dec.form    = OLD_FORM_REG_DIR;
			next_dec.length  = OLD_LEN_2;
		end else if (opc == OLD_OPC_CJAI) begin
			next_dec.op      = OLD_OP_COMPARE_JUMP;
			next_dec.form    = OLD_FORM_ACC_IMM_REL;
			next_dec.length  = OLD_LEN_3;
			next_dec.has_rel = 1'b1;
		end else if (opc == OLD_OPC_CJAD) begin
			next_dec.op      = OLD_OP_COMPARE_JUMP;
			next_dec.form    = OLD_FORM_ACC_DIR_REL;
			next_dec.length  = OLD_LEN_3;
			next_dec.has_rel = 1'b1;
		end else if (opc[7:3] == OLD_GRP_CJRI) begin
			next_dec.op      = OLD_OP_COMPARE_JUMP;
			next_dec.form    = OLD_FORM_REG_IMM;
			next_dec.length  = OLD_LEN_3;
			next_dec.has_rel = 1'b1;
		end else if (opc == OLD_OPC_CLRB) begin
			next_dec.op      = OLD_OP_CLEAR_BIT;
			next_dec.form    = OLD_FORM_BIT;
			next_dec.length  = OLD_LEN_2;
		end else if (opc == OLD_OPC_CLRC) begin
			next_dec.op      = OLD_OP_CLEAR_CARRY;
		end
	end

	// ----------------------------------------
	// target arithmetic
	// ----------------------------------------
	// the offset is the last byte, so the next address is pc plus full length
	assign next_pc = tgt_in.pc + {{(OLD_ADDR_W-2){1'b0}}, next_dec.length};

	olendec_target u_target (
		.next_pc     (next_pc),
		.rel         (tgt_in.rel),
		.page_hi     (opc[7:5]),
		.page_lo     (tgt_in.low),
		.rel_target  (rel_t),
		.page_target (page_t)
	);

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	// length registered on the presenting edge so fetch sees it one edge on
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			len_now   <= OLD_LEN_1;
			dec_valid <= 1'b0;
		end else begin
			len_now   <= next_dec.length;
			dec_valid <= opc_valid;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dec         <= '0;
			rel_target  <= '0;
			page_target <= '0;
		end else if (opc_valid) begin
			dec         <= next_dec;
			rel_target  <= rel_t;
			page_target <= page_t;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_jb_length: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc == 8'h20 |=> dec.length == 2'h3 && dec.has_rel)
		else $error("bit-set jump length wrong");
	a_jnb_op: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc == 8'h30 |=> dec.op == OLD_OP_JUMP_BIT_CLEAR && dec.length == 2'h3)
		else $error("bit-clear jump decode wrong");
	a_pcall_page: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc == 8'h31 |=> dec.length == 2'h2
			&& page_target[15:11] == $past(next_pc[15:11])
			&& page_target[10:8] == 3'h1)
		else $error("page call target wrong");
	a_iret_len: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc == 8'h32 |=> dec.op == OLD_OP_INT_RETURN && dec.length == 2'h1)
		else $error("interrupt return decode wrong");
	a_rel_target: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc == 8'h80 |=> rel_target
			== 16'($past(tgt_in.pc) + 16'h2 + {{8{$past(tgt_in.rel[7])}}, $past(tgt_in.rel)}))
		else $error("relative target wrong");
	a_ldimm_reg: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc[7:3] == 5'h0f |=> dec.op == OLD_OP_LOAD_REG_IMM
			&& dec.reg_sel == $past(opc[2:0]) && dec.length == 2'h2)
		else $error("immediate register load wrong");
	a_rsvd_flag: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc == 8'ha5 |=> dec.undefined && dec.op == OLD_OP_UNDEFINED)
		else $error("reserved opcode not flagged");
	a_compare_jump_unequal_len: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && (opc == 8'hb4 || opc == 8'hb5 || opc[7:3] == 5'h17)
			|=> dec.op == OLD_OP_COMPARE_JUMP && dec.length == 2'h3)
		else $error("compare jump decode wrong");
	a_len_follow: assert property (@(posedge clk_sys) disable iff (rst)
		opc == 8'h90 ##1 opc == 8'h93 |-> len_now == 2'h3 ##1 len_now == 2'h1)
		else $error("length not presented in step");

	// ----------------------------------------
	// per-opcode decode checks
	// ----------------------------------------
	// each check but a_clear_decode and a_pjump_page ties one opcode or group to its class and byte count, so a slip in the
	// if-chain order shows up as a wrong class rather than a silent length error
	a_jz_decode: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc == OLD_OPC_JZ
		|=> dec.op == OLD_OP_JUMP_ACC_ZERO && dec.length == OLD_LEN_2 && dec.has_rel)
		else $error("zero jump decode wrong");
	a_jnz_decode: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc == OLD_OPC_JNZ
		|=> dec.op == OLD_OP_JUMP_ACC_NZERO && dec.length == OLD_LEN_2 && dec.has_rel)
		else $error("nonzero jump decode wrong");
	a_orc_decode: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc == OLD_OPC_ORC
		|=> dec.op == OLD_OP_OR_BIT_CARRY && dec.length == OLD_LEN_2)
		else $error("or into carry decode wrong");
	a_sj_decode: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc == OLD_OPC_SJ
		|=> dec.op == OLD_OP_SHORT_JUMP && dec.length == OLD_LEN_2 && dec.has_rel)
		else $error("short jump decode wrong");
	a_andc_decode: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc == OLD_OPC_ANDC
		|=> dec.op == OLD_OP_AND_BIT_CARRY && dec.length == OLD_LEN_2)
		else $error("and into carry decode wrong");
	a_div_decode: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc == OLD_OPC_DIV
		|=> dec.op == OLD_OP_DIVIDE && dec.length == OLD_LEN_1)
		else $error("divide decode wrong");
	a_movdd_decode: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc == OLD_OPC_MOVDD
		|=> dec.op == OLD_OP_MOVE_DIR_DIR && dec.length == OLD_LEN_3)
		else $error("direct move decode wrong");
	a_stdir_decode: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc[7:3] == OLD_GRP_STDIR
		|=> dec.op == OLD_OP_STORE_REG_DIR && dec.length == OLD_LEN_2)
		else $error("register store decode wrong");
	a_ldptr_decode: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc == OLD_OPC_LDPTR
		|=> dec.op == OLD_OP_LOAD_PTR_IMM && dec.length == OLD_LEN_3)
		else $error("pointer load decode wrong");
	a_stc_decode: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc == OLD_OPC_STC
		|=> dec.op == OLD_OP_STORE_CARRY_BIT && dec.length == OLD_LEN_2)
		else $error("carry store decode wrong");
	a_cread_decode: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc == OLD_OPC_CREAD
		|=> dec.op == OLD_OP_CODE_READ && dec.length == OLD_LEN_1)
		else $error("code read decode wrong");
	a_subtract_with_borrow_decode: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc[7:3] == OLD_GRP_SUBTRACT_WITH_BORROW
		|=> dec.op == OLD_OP_SUB_BORROW && dec.length == OLD_LEN_1)
		else $error("subtract decode wrong");
	a_incptr_decode: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc == OLD_OPC_INCPTR
		|=> dec.op == OLD_OP_INC_PTR && dec.length == OLD_LEN_1)
		else $error("pointer increment decode wrong");
	a_mul_decode: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc == OLD_OPC_MUL
		|=> dec.op == OLD_OP_MULTIPLY && dec.length == OLD_LEN_1 && !dec.undefined)
		else $error("multiply decode wrong");
	a_lddir_decode: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc[7:3] == OLD_GRP_LDDIR
		|=> dec.op == OLD_OP_LOAD_REG_DIR && dec.length == OLD_LEN_2)
		else $error("register load decode wrong");
	a_clear_decode: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && (opc == OLD_OPC_CLRB || opc == OLD_OPC_CLRC)
		|=> dec.op == OLD_OP_CLEAR_BIT || dec.op == OLD_OP_CLEAR_CARRY)
		else $error("clear decode wrong");
	a_pjump_page: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc[4:0] == OLD_PJ_LOW
		|=> dec.op == OLD_OP_PAGE_JUMP && page_target[15:11] == $past(next_pc[15:11]))
		else $error("page jump target wrong");

	// ----------------------------------------
	// output timing and undefined-flag checks
	// ----------------------------------------
	a_len_step: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid
		|=> len_now == dec.length)
		else $error("length and decode disagree");
	a_valid_step: assert property (@(posedge clk_sys) disable iff (rst)
		1'b1
		|=> dec_valid == $past(opc_valid))
		else $error("decode valid out of step");
	a_undef_only: assert property (@(posedge clk_sys) disable iff (rst)
		opc_valid && opc != OLD_OPC_RSVD
		|=> !dec.undefined)
		else $error("defined opcode flagged undefined");
	// fetch may stall; the sequencer still reads dec, so it must not drift
	a_dec_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!opc_valid
		|=> $stable(dec) && $stable(rel_target))
		else $error("decode moved without a valid byte");

	c_short_back: cover property (@(posedge clk_sys) opc_valid && opc == 8'h80 && tgt_in.rel[7]);
	c_reserved: cover property (@(posedge clk_sys) opc_valid && opc == 8'ha5);
	c_compare_jump_unequal_reg: cover property (@(posedge clk_sys) opc_valid && opc == 8'hbf);
	c_len_pair: cover property (@(posedge clk_sys) opc == 8'h90 ##1 opc == 8'h93);

endmodule // olendec_top

// File: verification/olendec_fetch_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// fetch unit model: presents opcode bytes
// ----------------------------------------
module olendec_fetch_model
	import olendec_pkg::*;
(
	input  wire logic            clk_sys,
	input  wire logic            rst,
	input  wire logic            go,
	input  wire logic [7:0]      opc_in,
	input  wire olendec_tgt_in_t tgt_req,
	output logic                 opc_valid,
	output logic      [7:0]      opc,
	output olendec_tgt_in_t      tgt_in
);
	logic [7:0]      last_opc;
	olendec_tgt_in_t last_tgt;

	// idle cycles show a pattern that flips every cycle, so a stale byte never looks valid
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			last_opc <= 8'h00;
			last_tgt <= '0;
		end else if (go) begin
			last_opc <= opc_in;
			last_tgt <= tgt_req;
		end else begin
			last_opc <= ~last_opc;
			last_tgt <= ~last_tgt;
		end
	end

	// operand bytes travel in the same cycle as the opcode byte
	assign opc_valid = go;
	assign opc       = go ? opc_in : ~last_opc;
	assign tgt_in    = go ? tgt_req : ~last_tgt;
endmodule // olendec_fetch_model

// File: verification/test_opcode_length_decoder.sv
`timescale 1ns/1ps
module test_opcode_length_decoder
	import olendec_pkg::*;
;
	typedef struct packed {
		olendec_dec_t d;
		logic [15:0]  rt;
		logic [15:0]  pt;
		logic         pg;
	} olendec_exp_t;

	logic                  clk_sys = 1'b0;
	logic                  rst = 1'b1;
	logic                  go = 1'b0;
	logic [7:0]            opc_r = 8'h00;
	olendec_tgt_in_t       tgt_r = '0;
	logic                  opc_valid;
	logic [7:0]            opc;
	olendec_tgt_in_t       tgt_in;
	logic [1:0]            len_now;
	olendec_dec_t          dec;
	logic                  dec_valid;
	logic [OLD_ADDR_W-1:0] rel_target;
	logic [OLD_ADDR_W-1:0] page_target;
	olendec_exp_t          q[$];
	olendec_exp_t          e;
	logic [7:0]            prev_opc = 8'h00;
	logic                  rst_d = 1'b1;
	int                    edges = 0;
	int                    n_errors = 0;
	int                    cmp_count = 0;
	int                    seed = 32'h48ef529f;

	always #5 clk_sys = ~clk_sys;

	olendec_fetch_model fetch_u (.clk_sys(clk_sys), .rst(rst), .go(go), .opc_in(opc_r),
		.tgt_req(tgt_r), .opc_valid(opc_valid), .opc(opc), .tgt_in(tgt_in));

	olendec_top dut_u (.clk_sys(clk_sys), .rst(rst), .opc_valid(opc_valid), .opc(opc),
		.tgt_in(tgt_in), .len_now(len_now), .dec(dec), .dec_valid(dec_valid),
		.rel_target(rel_target), .page_target(page_target));

	// ----------------------------------------
	// reference decode
	// ----------------------------------------
	function automatic olendec_dec_t mk(olendec_op_t op, olendec_form_t f, logic [1:0] n,
		logic r, logic [7:0] o);
		olendec_dec_t d;
		d.op        = op;
		d.form      = f;
		d.length    = n;
		d.reg_sel   = o[2:0];
		d.has_rel   = r;
		d.undefined = (op == OLD_OP_UNDEFINED);
		return d;
	endfunction

	function automatic olendec_exp_t model(logic [7:0] o, olendec_tgt_in_t t);
		olendec_exp_t x;
		logic [15:0]  npc;
		x.d = mk(OLD_OP_OTHER, OLD_FORM_NONE, 2'h1, 1'b0, o);
		x.pg = 1'b0;
		casez (o)
			8'h20: x.d = mk(OLD_OP_JUMP_BIT_SET, OLD_FORM_BIT_REL, 2'h3, 1'b1, o);
			8'h30: x.d = mk(OLD_OP_JUMP_BIT_CLEAR, OLD_FORM_BIT_REL, 2'h3, 1'b1, o);
			8'h32: x.d = mk(OLD_OP_INT_RETURN, OLD_FORM_NONE, 2'h1, 1'b0, o);
			8'h60: x.d = mk(OLD_OP_JUMP_ACC_ZERO, OLD_FORM_REL, 2'h2, 1'b1, o);
			8'h70: x.d = mk(OLD_OP_JUMP_ACC_NZERO, OLD_FORM_REL, 2'h2, 1'b1, o);
			8'h72: x.d = mk(OLD_OP_OR_BIT_CARRY, OLD_FORM_BIT, 2'h2, 1'b0, o);
			8'h80: x.d = mk(OLD_OP_SHORT_JUMP, OLD_FORM_REL, 2'h2, 1'b1, o);
			8'h82: x.d = mk(OLD_OP_AND_BIT_CARRY, OLD_FORM_BIT, 2'h2, 1'b0, o);
			8'h84: x.d = mk(OLD_OP_DIVIDE, OLD_FORM_ACC_AUX, 2'h1, 1'b0, o);
			8'h85: x.d = mk(OLD_OP_MOVE_DIR_DIR, OLD_FORM_DIR_DIR, 2'h3, 1'b0, o);
			8'h90: x.d = mk(OLD_OP_LOAD_PTR_IMM, OLD_FORM_PTR_IMM16, 2'h3, 1'b0, o);
			8'h92: x.d = mk(OLD_OP_STORE_CARRY_BIT, OLD_FORM_BIT, 2'h2, 1'b0, o);
			8'h93: x.d = mk(OLD_OP_CODE_READ, OLD_FORM_ACC_PTR, 2'h1, 1'b0, o);
			8'ha3: x.d = mk(OLD_OP_INC_PTR, OLD_FORM_PTR, 2'h1, 1'b0, o);
			8'ha4: x.d = mk(OLD_OP_MULTIPLY, OLD_FORM_ACC_AUX, 2'h1, 1'b0, o);
			8'ha5: x.d = mk(OLD_OP_UNDEFINED, OLD_FORM_NONE, 2'h1, 1'b0, o);
			8'hb4: x.d = mk(OLD_OP_COMPARE_JUMP, OLD_FORM_ACC_IMM_REL, 2'h3, 1'b1, o);
			8'hb5: x.d = mk(OLD_OP_COMPARE_JUMP, OLD_FORM_ACC_DIR_REL, 2'h3, 1'b1, o);
			8'hc2: x.d = mk(OLD_OP_CLEAR_BIT, OLD_FORM_BIT, 2'h2, 1'b0, o);
			8'hc3: x.d = mk(OLD_OP_CLEAR_CARRY, OLD_FORM_NONE, 2'h1, 1'b0, o);
			8'b01111???: x.d = mk(OLD_OP_LOAD_REG_IMM, OLD_FORM_REG_IMM, 2'h2, 1'b0, o);
			8'b10001???: x.d = mk(OLD_OP_STORE_REG_DIR, OLD_FORM_DIR_REG, 2'h2, 1'b0, o);
			8'b10011???: x.d = mk(OLD_OP_SUB_BORROW, OLD_FORM_ACC_REG, 2'h1, 1'b0, o);
			8'b10101???: x.d = mk(OLD_OP_LOAD_REG_DIR, OLD_FORM_REG_DIR, 2'h2, 1'b0, o);
			8'b10111???: x.d = mk(OLD_OP_COMPARE_JUMP, OLD_FORM_REG_IMM, 2'h3, 1'b1, o);
			8'b???10001: x.d = mk(OLD_OP_PAGE_CALL, OLD_FORM_PAGE_ADDR, 2'h2, 1'b0, o);
			8'b???00001: x.d = mk(OLD_OP_PAGE_JUMP, OLD_FORM_PAGE_ADDR, 2'h2, 1'b0, o);
			default: ;
		endcase
		x.pg = (x.d.form == OLD_FORM_PAGE_ADDR);
		npc  = t.pc + {14'h0000, x.d.length};
		x.rt = npc + {{8{t.rel[7]}}, t.rel};
		x.pt = {npc[15:11], o[7:5], t.low};
		return x;
	endfunction

	// ----------------------------------------
	// checking and verdict
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done();
		if (n_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic send(input logic v, input logic [7:0] o, input olendec_tgt_in_t t);
		go    <= v;
		opc_r <= o;
		tgt_r <= t;
		if (v)
			q.push_back(model(o, t));
		@(posedge clk_sys);
	endtask

	always @(posedge clk_sys) begin
		if (edges > 0)
			chk("len_now", len_now, rst_d ? 2'h1 : model(prev_opc, '0).d.length);
		edges++;
		prev_opc <= opc;
		rst_d    <= rst;
		if (dec_valid === 1'b1) begin
			if (q.size() == 0) begin
				chk("dec_valid", 1'b1, 1'b0);
			end else begin
				e = q.pop_front();
				chk("dec", dec, e.d);
				if (e.d.has_rel)
					chk("rel_target", rel_target, e.rt);
				if (e.pg)
					chk("page_target", page_target, e.pt);
			end
		end
	end

	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial begin
		olendec_tgt_in_t t;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk("dec reset", dec, '0);
		chk("dec_valid reset", dec_valid, 1'b0);
		chk("targets reset", {rel_target, page_target}, 32'h0);
		@(posedge clk_sys);
		// both offset extremes, a page boundary and address wrap, every opcode back to back
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 256; i++) begin
				t.pc  = p ? 16'hfffe : 16'h07fe;
				t.rel = p ? 8'h80 : 8'h7f;
				t.low = $random(seed);
				send(1'b1, i[7:0], t);
			end
		end
		// pointer load then code read, back to back, for the length step check
		send(1'b1, OLD_OPC_LDPTR, t);
		send(1'b1, OLD_OPC_CREAD, t);
		go <= 1'b0;
		for (int k = 0; k < 10 && q.size() != 0; k++)
			@(posedge clk_sys);
		// second reset in mid-run, with nothing in flight
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk("dec mid reset", dec, '0);
		chk("dec_valid mid reset", dec_valid, 1'b0);
		@(posedge clk_sys);
		// random stream with idle gaps from a slow fetch side
		for (int i = 0; i < 400; i++) begin
			t = $random(seed);
			send(($random(seed) & 3) != 0, $random(seed), t);
		end
		go <= 1'b0;
		for (int k = 0; k < 10 && q.size() != 0; k++)
			@(posedge clk_sys);
		chk("pending results", q.size(), 0);
		test_done();
	end
endmodule // test_opcode_length_decoder
